// >>> core/cbs_pkg.sv
// Constants, register map and carrier types of the cam bank select and fault supervisor.
// Assumes a single 50 MHz clock domain.
package cbs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLEAR_HOLD_MS = 3000;
  localparam int unsigned COPY_SHOW_MS = 1000;
  localparam int unsigned CLEAR_HOLD_CYC = CLK_HZ / 1000 * CLEAR_HOLD_MS;
  localparam int unsigned COPY_SHOW_CYC = CLK_HZ / 1000 * COPY_SHOW_MS;
  localparam int CNT_W = 28;
  localparam int ADDR_W = 8;
  localparam int CAM_W = 16;
  localparam int SYNC_W = 9;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] COPY_OFS = 8'h08;
  localparam int CTRL_BANK_EN_BIT = 0;
  localparam int CTRL_METHOD_BIT = 1;
  localparam int CTRL_LOSS_BIT = 2;
  localparam int COPY_BANK_POS = 0;
  localparam int COPY_DST_POS = 4;
  localparam int COPY_CONFIRM_BIT = 8;
  localparam int STAT_BANK_POS = 0;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_SHOW_BIT = 4;
  localparam int STAT_FAULT_POS = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CBS_MODE_PRGM, CBS_MODE_RUN, CBS_MODE_TEST, CBS_MODE_FUNC} cbs_mode_t;
  typedef enum logic [2:0] {CP_IDLE, CP_DST, CP_EXEC, CP_BUSY, CP_SHOW} cbs_copy_t;

  typedef struct packed {
    logic loss_detect;
    logic method_key;
    logic bank_enable;
  } cbs_settings_t;

  // Loss detection on, banking off, bank inputs selected
  localparam cbs_settings_t SETTINGS_RST = 3'h4;

  typedef struct packed {
    logic resolution;
    logic enc_data;
    logic overspeed;
    logic cpu;
    logic checksum;
    logic ram;
    logic origin;
  } cbs_diag_t;

  typedef struct packed {
    logic enc_disc;
    cbs_diag_t diag;
  } cbs_faults_t;
endpackage

// >>> core/cbs_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the levels change slowly compared with the clock.
`timescale 1ns/1ps
`default_nettype none
module cbs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> core/cbs_top.sv
// Bank selection, bank copy sequencing and fault supervision of a cam positioner.
// Assumes an AXI4-Lite master, pins from switches and an encoder, program memory on clk_i.
// Contract
// - Banking off after reset until enabled.
// - Input mode takes bank from inputs only.
// - Key mode uses bank key, ignores inputs.
// - Method change accepted only with banking on.
// - Bank is inputs weighted 1,2,4, low-active.
// - Copy rejected while banking is off.
// - Copy needs source, destination, execute confirms.
// - Completion shown for one second after copy.
// - Loss detect flags missing encoder in run.
// - Loss detect off never flags missing encoder.
// - Any fault forces cam, pulse, run off.
// - Origin/checksum fault cleared by 3 s clear.
// - Memory or processor fault needs power cycle.
// - Overspeed clears on program-to-run when slow.
// - Encoder data fault clears only on reset.
// - Resolution mismatch clears only on reset.
// - Disconnect clears on program-to-run when connected.
`timescale 1ns/1ps
`default_nettype none
module cbs_top #(
  parameter int unsigned CLEAR_HOLD_CYCLES = cbs_pkg::CLEAR_HOLD_CYC,
  parameter int unsigned COPY_SHOW_CYCLES = cbs_pkg::COPY_SHOW_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [cbs_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] mode_i,
  input wire logic start_i,
  input wire logic [2:0] bank_sel_n_i,
  input wire logic bank_key_i,
  input wire logic clear_key_i,
  input wire logic encoder_present_i,
  input wire cbs_pkg::cbs_diag_t diag_i,
  input wire logic [cbs_pkg::CAM_W-1:0] cam_i,
  input wire logic pulse_i,
  input wire logic run_i,
  input wire logic copy_done_i,
  output logic [cbs_pkg::CAM_W-1:0] cam_o,
  output logic pulse_o,
  output logic run_o,
  output logic [2:0] active_bank_o,
  output logic copy_req_o,
  output logic [2:0] copy_src_o,
  output logic [2:0] copy_dst_o,
  output logic reinit_o,
  output cbs_pkg::cbs_faults_t faults_o
);
  import cbs_pkg::*;
  // Index 0..2 for the three registers, 3 for an unmapped address
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFS) ? 2'h0 : (a == STATUS_OFS) ? 2'h1 : (a == COPY_OFS) ? 2'h2 : 2'h3;
  endfunction
  logic [SYNC_W-1:0] pins_s;
  cbs_sync #(.W(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({mode_i, start_i, bank_sel_n_i, bank_key_i, clear_key_i, encoder_present_i}),
    .sync_o(pins_s)
  );
  wire cbs_mode_t mode = cbs_mode_t'(pins_s[8:7]);
  wire start_s = pins_s[6];
  wire [2:0] bank_in = ~pins_s[5:3];
  wire key_s = pins_s[2];
  wire clear_s = pins_s[1];
  wire enc_present_s = pins_s[0];
  cbs_mode_t mode_d_reg;
  logic start_d_reg;
  logic key_d_reg;
  wire run_like = (mode == CBS_MODE_RUN) || (mode == CBS_MODE_TEST);
  wire was_run_like = (mode_d_reg == CBS_MODE_RUN) || (mode_d_reg == CBS_MODE_TEST);
  wire enter_run = run_like && !was_run_like;
  wire prog_to_run = (mode == CBS_MODE_RUN) && (mode_d_reg == CBS_MODE_PRGM);
  wire start_rise = start_s && !start_d_reg;
  wire key_rise = key_s && !key_d_reg;
  // Bus slave: address and data are held separately so they may come in either order
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  wire [1:0] wr_sel = reg_sel(aw_addr_reg);
  wire wr_ctrl = wr_fire && (wr_sel == 2'h0) && w_strb_reg[0];
  wire wr_copy = wr_fire && (wr_sel == 2'h2) && w_strb_reg[0] && w_strb_reg[1];
  wire [2:0] wr_bank = w_data_reg[COPY_BANK_POS +: 3];
  wire wr_confirm = w_data_reg[COPY_CONFIRM_BIT];
  wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire [1:0] rd_sel = reg_sel(s_axi_araddr_i);
  cbs_settings_t settings_reg;
  cbs_faults_t faults_next;
  cbs_copy_t cp_state;
  logic [CNT_W-1:0] show_cnt;
  logic [CNT_W-1:0] clr_cnt;
  wire recover_fire;
  // Method is latched from the old enable so one write cannot enable and switch at once
  cbs_settings_t settings_next;
  assign settings_next.bank_enable = wr_ctrl ? w_data_reg[CTRL_BANK_EN_BIT]
                                             : settings_reg.bank_enable;
  assign settings_next.method_key = (wr_ctrl && settings_reg.bank_enable) ?
                                    w_data_reg[CTRL_METHOD_BIT] : settings_reg.method_key;
  assign settings_next.loss_detect = wr_ctrl ? w_data_reg[CTRL_LOSS_BIT]
                                             : settings_reg.loss_detect;
  // Bank choice; the controller toggles start to pick up new inputs
  wire [2:0] bank_next =
    !settings_reg.bank_enable ? 3'h0 :
    settings_reg.method_key ? (key_rise ? active_bank_o + 3'h1 : active_bank_o) :
    (run_like && (enter_run || start_rise)) ? bank_in : active_bank_o;
  // Hardware set always wins over a clear in the same cycle
  wire disc_set = settings_reg.loss_detect && run_like && !enc_present_s;
  wire clr_soft = recover_fire;
  assign faults_next.diag.origin = diag_i.origin || (faults_o.diag.origin && !clr_soft);
  assign faults_next.diag.checksum = diag_i.checksum || (faults_o.diag.checksum && !clr_soft);
  assign faults_next.diag.ram = diag_i.ram || faults_o.diag.ram;
  assign faults_next.diag.cpu = diag_i.cpu || faults_o.diag.cpu;
  assign faults_next.diag.overspeed = diag_i.overspeed ||
                                      (faults_o.diag.overspeed && !prog_to_run);
  assign faults_next.diag.enc_data = diag_i.enc_data || faults_o.diag.enc_data;
  assign faults_next.diag.resolution = diag_i.resolution || faults_o.diag.resolution;
  assign faults_next.enc_disc = disc_set || (faults_o.enc_disc && !prog_to_run);
  wire fault_any_next = |faults_next;
  // Clear-key hold timer; settings fall back to their reset values on recovery
  wire soft_fault = faults_o.diag.origin || faults_o.diag.checksum;
  wire clr_hold_done = clr_cnt == CNT_W'(CLEAR_HOLD_CYCLES - 1);
  wire clr_restart = !clear_s || !soft_fault || clr_hold_done;
  assign recover_fire = clear_s && soft_fault && clr_hold_done;
  // Outputs go off at the very edge a fault latches, and stay off while any is held
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_d_reg <= CBS_MODE_PRGM;
      start_d_reg <= 1'b0;
      key_d_reg <= 1'b0;
      settings_reg <= SETTINGS_RST;
      active_bank_o <= 3'h0;
      faults_o <= '0;
      reinit_o <= 1'b0;
      clr_cnt <= '0;
      cam_o <= '0;
      pulse_o <= 1'b0;
      run_o <= 1'b0;
    end
    else
    begin
      mode_d_reg <= mode;
      start_d_reg <= start_s;
      key_d_reg <= key_s;
      settings_reg <= recover_fire ? SETTINGS_RST : settings_next;
      active_bank_o <= recover_fire ? 3'h0 : bank_next;
      faults_o <= faults_next;
      reinit_o <= recover_fire;
      clr_cnt <= clr_restart ? '0 : clr_cnt + CNT_W'(1);
      cam_o <= fault_any_next ? '0 : cam_i;
      pulse_o <= !fault_any_next && pulse_i;
      run_o <= !fault_any_next && run_i;
    end
  end
  // Copy: first confirm takes the source, second the destination, third starts it
  wire copy_ok = settings_reg.bank_enable && (mode == CBS_MODE_PRGM);
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cp_state <= CP_IDLE;
      show_cnt <= '0;
      copy_req_o <= 1'b0;
      copy_src_o <= 3'h0;
      copy_dst_o <= 3'h0;
    end
    else
    begin
      case (cp_state)
        CP_IDLE:
          if (wr_copy && wr_confirm && copy_ok)
          begin
            copy_src_o <= wr_bank;
            cp_state <= CP_DST;
          end
        CP_DST, CP_EXEC:
          if (!copy_ok || (wr_copy && !wr_confirm))
            cp_state <= CP_IDLE;
          else if (wr_copy && cp_state == CP_DST)
          begin
            copy_dst_o <= wr_bank;
            cp_state <= CP_EXEC;
          end
          else if (wr_copy)
          begin
            copy_req_o <= 1'b1;
            cp_state <= CP_BUSY;
          end
        CP_BUSY:
          if (copy_done_i)
          begin
            copy_req_o <= 1'b0;
            show_cnt <= CNT_W'(COPY_SHOW_CYCLES - 1);
            cp_state <= CP_SHOW;
          end
        CP_SHOW:
          if (show_cnt == '0)
            cp_state <= CP_IDLE;
          else
            show_cnt <= show_cnt - CNT_W'(1);
        default:
          cp_state <= CP_IDLE;
      endcase
    end
  end
  logic [31:0] status_word;
  always_comb
  begin
    status_word = '0;
    status_word[STAT_BANK_POS +: 3] = active_bank_o;
    status_word[STAT_BUSY_BIT] = cp_state == CP_BUSY;
    status_word[STAT_SHOW_BIT] = cp_state == CP_SHOW;
    status_word[STAT_FAULT_POS +: 8] = faults_o;
  end
  wire [31:0] rd_word = (rd_sel == 2'h0) ? {29'h0, settings_reg} :
                        (rd_sel == 2'h1) ? status_word :
                        (rd_sel == 2'h2) ? {25'h0, copy_dst_o, 1'b0, copy_src_o} : 32'h0;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_addr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= (rd_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_bank_off_zero: assert property (!settings_reg.bank_enable |=> active_bank_o == 3'h0)
    else $error("bank not zero while banking off");
  chk_input_bank_take: assert property (
    settings_reg.bank_enable && !settings_reg.method_key && run_like && start_rise && !recover_fire
    |=> active_bank_o == ~$past(pins_s[5:3]))
    else $error("bank inputs not taken on start");
  chk_key_mode_hold: assert property (
    settings_reg.bank_enable && settings_reg.method_key && !key_rise && !recover_fire
    |=> $stable(active_bank_o))
    else $error("key mode bank moved without key");
  chk_method_locked: assert property (!settings_reg.bank_enable && !recover_fire
    |=> $stable(settings_reg.method_key)) else $error("method changed with banking off");
  chk_copy_rejected: assert property (
    cp_state == CP_IDLE && !settings_reg.bank_enable |=> cp_state == CP_IDLE)
    else $error("copy started with banking off");
  chk_copy_show_time: assert property (
    cp_state == CP_BUSY && copy_done_i |=> cp_state == CP_SHOW && show_cnt == CNT_W'(COPY_SHOW_CYCLES - 1))
    else $error("completion indication not started");
  chk_outputs_forced: assert property (
    (|faults_o) |-> cam_o == '0 && !pulse_o && !run_o)
    else $error("output active during fault");
  chk_loss_flag: assert property (disc_set |=> faults_o.enc_disc)
    else $error("missing encoder not flagged");
  chk_loss_disabled: assert property (
    !settings_reg.loss_detect && !faults_o.enc_disc |=> !faults_o.enc_disc)
    else $error("disconnect flagged with detection off");
  chk_hard_sticky: assert property (
    !$fell(faults_o.diag.ram) && !$fell(faults_o.diag.cpu) && !$fell(faults_o.diag.enc_data)
    && !$fell(faults_o.diag.resolution))
    else $error("hard fault cleared without reset");
  chk_soft_recover: assert property ($fell(faults_o.diag.origin) |-> reinit_o)
    else $error("origin fault cleared without clear hold");
  chk_run_recover: assert property (
    $fell(faults_o.diag.overspeed) || $fell(faults_o.enc_disc) |-> $past(prog_to_run))
    else $error("speed or disconnect fault cleared early");
endmodule
`default_nettype wire

// >>> sim/cbs_far_model.sv
// Far side of the supervisor: program memory that completes copies, cam logic outputs.
// Assumes the block's clock; slow_i stretches the copy time.
`timescale 1ns/1ps
`default_nettype none
module cbs_far_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic copy_req_i,
  input wire logic slow_i,
  output logic copy_done_o,
  output logic [cbs_pkg::CAM_W-1:0] cam_o,
  output logic pulse_o,
  output logic run_o
);
  import cbs_pkg::*;
  logic [4:0] wait_reg;
  // Pattern moves every cycle so a stuck output gate cannot hide
  assign pulse_o = cam_o[0];
  assign run_o = cam_o[1];
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wait_reg <= 5'h0;
      copy_done_o <= 1'b0;
      cam_o <= '0;
    end
    else
    begin
      cam_o <= cam_o + 1'b1;
      wait_reg <= copy_req_i ? wait_reg + 5'h1 : 5'h0;
      // One done pulse per request; the request drops before a second match
      copy_done_o <= copy_req_i && (wait_reg == (slow_i ? 5'h0f : 5'h03));
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_cbs_top.sv
// Self-checking bench of the bank select and fault supervisor.
// Assumes cbs_pkg and the far-side model; short clear and show counts.
`timescale 1ns/1ps
`default_nettype none
module tb_cbs_top;
  import cbs_pkg::*;
  logic clk_i, reset_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic s_axi_rready_i, start_i, bank_key_i, clear_key_i, encoder_present_i, pulse_i, run_i;
  logic copy_done_i, pulse_o, run_o, copy_req_o, reinit_o, slow;
  logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, mode_i, r;
  logic [2:0] bank_sel_n_i, active_bank_o, copy_src_o, copy_dst_o;
  logic [CAM_W-1:0] cam_i, cam_o;
  cbs_diag_t diag_i;
  cbs_faults_t faults_o;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int reinits = 0;

  cbs_top #(.CLEAR_HOLD_CYCLES(20), .COPY_SHOW_CYCLES(10)) uut (.clk_i, .reset_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .mode_i, .start_i, .bank_sel_n_i, .bank_key_i,
    .clear_key_i, .encoder_present_i, .diag_i, .cam_i, .pulse_i, .run_i, .copy_done_i,
    .cam_o, .pulse_o, .run_o, .active_bank_o, .copy_req_o, .copy_src_o, .copy_dst_o,
    .reinit_o, .faults_o);
  cbs_far_model far (.clk_i, .reset_i, .copy_req_i(copy_req_o), .slow_i(slow),
    .copy_done_o(copy_done_i), .cam_o(cam_i), .pulse_o(pulse_i), .run_o(run_i));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (reinit_o === 1'b1) reinits++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {s_axi_awaddr_i, s_axi_wdata_i} <= {a, v};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
    s_axi_rready_i <= 1'b0;
  endtask

  // Outputs one cycle after the cam inputs, or all off while a fault stands
  task automatic chk_outs(input logic live);
    logic [17:0] c;
    @(negedge clk_i);
    c = live ? {run_i, pulse_i, cam_i} : 18'h0;
    @(negedge clk_i);
    chk({run_o, pulse_o, cam_o}, c);
    @(posedge clk_i);
  endtask

  // Start phases are shortened; the block does not time them
  task automatic tog;
    start_i <= 1'b0;
    cyc(4);
    start_i <= 1'b1;
    cyc(5);
  endtask

  task automatic t_reset;
    rd(CTRL_OFS);
    chk(d, 32'h4);
    mode_i <= 2'h1;
    bank_sel_n_i <= 3'h0;
    tog;
    chk(active_bank_o, 3'h0);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    wr(8'h40, 32'h7);
    chk(r, RESP_SLVERR);
  endtask

  task automatic t_method;
    wr(CTRL_OFS, 32'h6);
    rd(CTRL_OFS);
    chk(d, 32'h4);
    wr(CTRL_OFS, 32'h5);
    wr(CTRL_OFS, 32'h7);
    rd(CTRL_OFS);
    chk(d, 32'h7);
  endtask

  task automatic t_key;
    repeat (9)
    begin
      bank_key_i <= 1'b1;
      cyc(4);
      bank_key_i <= 1'b0;
      cyc(4);
    end
    chk(active_bank_o, 3'h1);
    bank_sel_n_i <= 3'h4;
    tog;
    chk(active_bank_o, 3'h1);
  endtask

  task automatic t_bank;
    wr(CTRL_OFS, 32'h5);
    for (int b = 0; b < 8; b++)
    begin
      bank_sel_n_i <= ~b[2:0];
      tog;
      chk(active_bank_o, b[2:0]);
    end
    mode_i <= 2'h0;
    bank_sel_n_i <= 3'h2;
    tog;
    chk(active_bank_o, 3'h7);
    mode_i <= 2'h1;
    cyc(5);
    chk(active_bank_o, 3'h5);
  endtask

  task automatic t_copy;
    mode_i <= 2'h0;
    wr(CTRL_OFS, 32'h4);
    wr(COPY_OFS, 32'h102);
    wr(COPY_OFS, 32'h103);
    wr(COPY_OFS, 32'h100);
    cyc(3);
    chk(copy_req_o, 1'b0);
    wr(CTRL_OFS, 32'h5);
    for (int s = 1; s >= 0; s--)
    begin
      slow <= s[0];
      wr(COPY_OFS, 32'h102);
      wr(COPY_OFS, 32'h103);
      wr(COPY_OFS, 32'h100);
      chk({copy_req_o, copy_src_o, copy_dst_o}, 7'h53);
      for (int n = 0; n < 40 && copy_req_o === 1'b1; n++) cyc(1);
      rd(STATUS_OFS);
      chk(d[STAT_SHOW_BIT], 1'b1);
      cyc(12);
      rd(STATUS_OFS);
      chk(d[4:3], 2'h0);
    end
  endtask

  task automatic t_loss;
    // Test mode here, so the loss flag is seen outside run mode as well
    mode_i <= 2'h2;
    encoder_present_i <= 1'b0;
    cyc(6);
    chk(faults_o.enc_disc, 1'b1);
    chk_outs(1'b0);
    encoder_present_i <= 1'b1;
    cyc(6);
    chk_outs(1'b0);
    mode_i <= 2'h0;
    cyc(5);
    mode_i <= 2'h1;
    cyc(5);
    chk(faults_o, 8'h0);
    chk_outs(1'b1);
    wr(CTRL_OFS, 32'h1);
    encoder_present_i <= 1'b0;
    cyc(6);
    chk(faults_o, 8'h0);
    encoder_present_i <= 1'b1;
  endtask

  task automatic t_diag;
    logic [6:0] m;
    logic ck;
    logic cl;
    for (int i = 0; i < 7; i++)
    begin
      m = 7'h1 << i;
      ck = (i == 0) || (i == 2);
      cl = ck || (i == 4);
      diag_i <= cbs_diag_t'(m);
      cyc(1);
      diag_i <= '0;
      cyc(3);
      chk(faults_o.diag, m);
      chk_outs(1'b0);
      clear_key_i <= 1'b1;
      cyc(10);
      clear_key_i <= 1'b0;
      cyc(4);
      chk(faults_o.diag, m);
      reinits = 0;
      clear_key_i <= 1'b1;
      cyc(30);
      clear_key_i <= 1'b0;
      mode_i <= 2'h0;
      cyc(5);
      mode_i <= 2'h1;
      cyc(5);
      chk(faults_o.diag, cl ? 7'h0 : m);
      chk(reinits, ck);
      chk_outs(cl);
      reset_i <= 1'b1;
      cyc(2);
      reset_i <= 1'b0;
      cyc(3);
      chk(faults_o, 8'h0);
    end
  endtask

  initial
  begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 4'h0;
    {s_axi_rready_i, start_i, bank_key_i, clear_key_i, slow} = 5'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    s_axi_wstrb_i = 4'hf;
    {mode_i, diag_i} = '0;
    bank_sel_n_i = 3'h7;
    encoder_present_i = 1'b1;
    reset_i = 1'b1;
    cyc(6);
    reset_i <= 1'b0;
    cyc(2);
    t_reset;
    t_method;
    t_key;
    t_bank;
    t_copy;
    t_loss;
    t_diag;
    report_and_stop;
  end
endmodule
`default_nettype wire
